// ===== gpc_pkg.sv
// gpc_pkg: constants for the general purpose port control block
// assumes a byte-wide register port and a 12-bit register address space
package gpc_pkg;
  localparam int           GPC_NUM_PINS     = 25;
  localparam int           GPC_PORT_W       = 8;
  localparam int           GPC_ADDR_W       = 12;
  localparam int           GPC_IRQ_N        = 8;
  // register addresses
  localparam logic [11:0]  GPC_ADDR_ENH1    = 12'h0fc4;
  localparam logic [11:0]  GPC_ADDR_SHSEL   = 12'h0fce;
  localparam logic [11:0]  GPC_ADDR_PADDR   = 12'h0fd0;
  localparam logic [11:0]  GPC_ADDR_PCTL    = 12'h0fd1;
  localparam logic [11:0]  GPC_PORT_STRIDE  = 12'h0004;
  // subregister code that selects the output control subregister
  localparam logic [7:0]   GPC_SUB_OUTCTL   = 8'h03;
  // subregister code for alternate function enable
  localparam logic [7:0]   GPC_SUB_AFEN     = 8'h02;
  localparam logic [7:0]   GPC_SUB_SEL2     = 8'h08;
  localparam logic [7:0]   GPC_SUB_DRIVE    = 8'h04;
  // field positions
  localparam int           GPC_SHARED_BIT   = 6;
  localparam int           GPC_SHARED_SEL   = 6;
  // reset values
  localparam logic [7:0]   GPC_RST_BYTE     = 8'h00;
  // priority codes
  typedef enum logic [1:0] {GPC_PRI_OFF, GPC_PRI_LOW, GPC_PRI_NOM, GPC_PRI_HIGH} gpc_pri_e;
endpackage

// ===== gpc_pin_drv.sv
// gpc_pin_drv: per-pin output drive for W pins; gpc_top uses one instance for all four 8-bit ports
// assumes data, direction and peripheral values are on mclk
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_drv
  import gpc_pkg::*;
#(
  parameter int W = 8
) (
  // software settings
  input  wire logic [W-1:0] out_data,
  input  wire logic [W-1:0] out_en,
  input  wire logic [W-1:0] af_en,
  input  wire logic [W-1:0] open_drain,
  // peripheral side
  input  wire logic [W-1:0] af_data,
  input  wire logic [W-1:0] af_oe,
  // pin side
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe
);
  genvar i;
  // one pin each; open drain acts after the function mux
  generate
    for (i = 0; i < W; i++) begin : g_pin
      logic lvl;
      logic drv;
      assign lvl = af_en[i] ? af_data[i] : out_data[i];
      assign drv = af_en[i] ? af_oe[i] : out_en[i];
      // high side cut when open drain is set, pin only sinks
      assign pin_o[i]  = lvl;
      assign pin_oe[i] = drv & (~open_drain[i] | ~lvl);
    end
  endgenerate
endmodule
`default_nettype wire

// ===== gpc_top.sv
// gpc_top: general purpose port control, ports A to D
// Behaviour
// - up to 25 pins over four ports, each pin set independently
// - port C pins drive LEDs with software-selected strength
// - port A timer functions on pins 0,1,6,7; pins 2 to 5 reserved
// - ports A and D: enable alone routes the single alternate function
// - ports B and C keep a second select register unused for routing
// - output control subregister reached when subregister address holds 03H
// - writing 1 to an output control bit makes that pin open drain
// - open drain acts on the pin even while an alternate function runs
// - a clear output control bit lets the pin drive both levels
// - open drain applies to alternate function and plain output alike
// - group 1 sources take priority from enable-high and enable-low pair
// - enable-high bit 6 serves the shared pin 6 or comparator source
// - enable-high bits 5 to 0 enable pin sources, A or D by select
// - shared select 0 routes port A pin 6, 1 the comparator
// assumes a byte register port on mclk; rd_data is valid the cycle after rd_en
`timescale 1ns/1ps
`default_nettype none
module gpc_top
  import gpc_pkg::*;
#(
  parameter int NPORT = 4
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // register port
  input  wire logic [GPC_ADDR_W-1:0] reg_addr,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  input  wire logic [7:0]            wr_data,
  output logic      [7:0]            rd_data,
  // group 1 enable-low bits from the interrupt controller
  input  wire logic [GPC_IRQ_N-1:0]  irq1_enable_low,
  // group 1 priority codes, two bits per source
  output logic [2*GPC_IRQ_N-1:0]     irq1_priority,
  // shared source selection
  output logic                       shared_source_select_bit,
  // port data and direction from the core
  input  wire logic [8*NPORT-1:0]    port_out_data,
  input  wire logic [8*NPORT-1:0]    port_out_en,
  // timer peripheral signals
  input  wire logic                  timer_zero_output,
  input  wire logic                  timer_zero_comp_out,
  input  wire logic                  timer_one_output,
  input  wire logic                  timer_one_comp_out,
  input  wire logic [8*NPORT-1:0]    periph_af_data,
  input  wire logic [8*NPORT-1:0]    periph_af_oe,
  // pins
  input  wire logic [8*NPORT-1:0]    pin_i,
  output logic      [8*NPORT-1:0]    pin_o,
  output logic      [8*NPORT-1:0]    pin_oe,
  output logic      [8*NPORT-1:0]    pin_in_sync,
  // port C drive strength
  output logic      [7:0]            port_c_drive_high,
  // timer inputs and clock input taken from pins
  output logic                       timer_zero_in_or_complement_out,
  output logic                       timer_one_in_or_complement_out,
  output logic                       external_clock_input_function
);
  // released reset
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // port address decode: base + port*stride
  logic [1:0]  port_sel;
  logic        hit_addr;
  logic        hit_ctl;
  logic [7:0]  sub_addr_r [NPORT];
  logic [7:0]  out_ctl_r  [NPORT];
  logic [7:0]  af_en_r    [NPORT];
  logic [7:0]  sel2_r     [NPORT];
  logic [7:0]  drive_r;
  logic [7:0]  enh_r;
  logic        shsel_r;
  logic [GPC_ADDR_W-1:0] off;

  always_comb begin
    off      = reg_addr - GPC_ADDR_PADDR;
    port_sel = off[3:2];
    hit_addr = (reg_addr >= GPC_ADDR_PADDR) && (off[11:4] == 8'h00) && (off[1:0] == 2'b00);
    hit_ctl  = (reg_addr >= GPC_ADDR_PADDR) && (off[11:4] == 8'h00) && (off[1:0] == 2'b01);
  end

  // per-port subregister address and indirect subregisters; each pin its own bit
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int p = 0; p < NPORT; p++) begin
        sub_addr_r[p] <= GPC_RST_BYTE;
        out_ctl_r[p]  <= GPC_RST_BYTE;
        af_en_r[p]    <= GPC_RST_BYTE;
        sel2_r[p]     <= GPC_RST_BYTE;
      end
    end else if (wr_en) begin
      if (hit_addr) begin
        sub_addr_r[port_sel] <= wr_data;
      end
      if (hit_ctl) begin
        unique case (sub_addr_r[port_sel])
          GPC_SUB_OUTCTL: out_ctl_r[port_sel] <= wr_data;
          GPC_SUB_AFEN:   af_en_r[port_sel]   <= wr_data;
          // only ports B and C hold a second select register
          GPC_SUB_SEL2: begin
            if (port_sel == 2'd1 || port_sel == 2'd2) begin
              sel2_r[port_sel] <= wr_data;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // port C drive strength subregister
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      drive_r <= GPC_RST_BYTE;
    end else if (wr_en && hit_ctl && port_sel == 2'd2 && sub_addr_r[2] == GPC_SUB_DRIVE) begin
      drive_r <= wr_data;
    end
  end

  // group 1 enable-high and shared select registers
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      enh_r   <= GPC_RST_BYTE;
      shsel_r <= 1'b0;
    end else if (wr_en) begin
      if (reg_addr == GPC_ADDR_ENH1) begin
        enh_r <= wr_data;
      end
      if (reg_addr == GPC_ADDR_SHSEL) begin
        shsel_r <= wr_data[GPC_SHARED_SEL];
      end
    end
  end

  // read data, registered; unmapped addresses read zero
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_data <= GPC_RST_BYTE;
    end else if (rd_en) begin
      if (reg_addr == GPC_ADDR_ENH1) begin
        rd_data <= enh_r;
      end else if (reg_addr == GPC_ADDR_SHSEL) begin
        rd_data <= {1'b0, shsel_r, 6'b00_0000};
      end else if (hit_addr) begin
        rd_data <= sub_addr_r[port_sel];
      end else if (hit_ctl) begin
        unique case (sub_addr_r[port_sel])
          GPC_SUB_OUTCTL: rd_data <= out_ctl_r[port_sel];
          GPC_SUB_AFEN:   rd_data <= af_en_r[port_sel];
          GPC_SUB_SEL2:   rd_data <= (port_sel == 2'd1 || port_sel == 2'd2) ? sel2_r[port_sel] : GPC_RST_BYTE;
          GPC_SUB_DRIVE:  rd_data <= (port_sel == 2'd2) ? drive_r : GPC_RST_BYTE;
          default:        rd_data <= GPC_RST_BYTE;
        endcase
      end else begin
        rd_data <= GPC_RST_BYTE;
      end
    end
  end

  // priority code per source: {enable high, enable low}
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq1_priority            <= '0;
      shared_source_select_bit <= 1'b0;
      port_c_drive_high        <= GPC_RST_BYTE;
    end else begin
      for (int k = 0; k < GPC_IRQ_N; k++) begin
        irq1_priority[2*k +: 2] <= {enh_r[k], irq1_enable_low[k]};
      end
      shared_source_select_bit <= shsel_r;
      port_c_drive_high        <= drive_r;
    end
  end

  // alternate function data per pin; port A timers fixed, B and C ignore the second select
  logic [8*NPORT-1:0] af_data;
  logic [8*NPORT-1:0] af_oe;
  logic [8*NPORT-1:0] af_en_flat;
  logic [8*NPORT-1:0] oc_flat;
  always_comb begin
    af_data = periph_af_data;
    af_oe   = periph_af_oe;
    // port A single functions: enable alone routes them
    af_data[0] = timer_zero_comp_out;
    af_data[1] = timer_zero_output;
    af_data[6] = timer_one_comp_out;
    af_data[7] = timer_one_output;
    af_oe[7:0] = {periph_af_oe[7:6], 4'h0, periph_af_oe[1:0]};             // reserved pins 2 to 5 never drive from the alternate function
    // port B pin 3 is an input when used as clock input
    af_oe[11]  = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      af_en_flat[8*p +: 8] = af_en_r[p];
      oc_flat[8*p +: 8]    = out_ctl_r[p];
    end
  end

  logic [8*NPORT-1:0] drv_o;
  logic [8*NPORT-1:0] drv_oe;
  gpc_pin_drv #(.W(8*NPORT)) u_drv (
    .out_data   (port_out_data),
    .out_en     (port_out_en),
    .af_en      (af_en_flat),
    .open_drain (oc_flat),
    .af_data    (af_data),
    .af_oe      (af_oe),
    .pin_o      (drv_o),
    .pin_oe     (drv_oe)
  );

  // pin outputs registered so the top drives from flops
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_o  <= '0;
      pin_oe <= '0;
    end else begin
      pin_o  <= drv_o;
      pin_oe <= drv_oe;
    end
  end

  // pin input synchroniser: three stages, change taken when 2nd and 3rd agree
  logic [8*NPORT-1:0] s1_r;
  logic [8*NPORT-1:0] s2_r;
  logic [8*NPORT-1:0] s3_r;
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s1_r        <= '0;
      s2_r        <= '0;
      s3_r        <= '0;
      pin_in_sync <= '0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int b = 0; b < 8*NPORT; b++) begin
        if (s2_r[b] == s3_r[b]) begin
          pin_in_sync[b] <= s3_r[b];
        end
      end
    end
  end

  // timer and clock inputs gated by the pin's alternate function enable
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      timer_zero_in_or_complement_out <= 1'b0;
      timer_one_in_or_complement_out  <= 1'b0;
      external_clock_input_function   <= 1'b0;
    end else begin
      timer_zero_in_or_complement_out <= af_en_r[0][0] & pin_in_sync[0];
      timer_one_in_or_complement_out  <= af_en_r[0][6] & pin_in_sync[6];
      external_clock_input_function   <= af_en_r[1][3] & pin_in_sync[11];
    end
  end
endmodule
`default_nettype wire

// ===== gpc_checker.sv
// gpc_checker: timing relations seen at the gpc_top ports
// assumes bind to gpc_top; port B outputs stay off while its alternate functions are on
`timescale 1ns/1ps
`default_nettype none
module gpc_checker
  import gpc_pkg::*;
#(
  parameter int NPORT = 4
) (
  // clock, reset and register port
  input wire logic                   mclk,
  input wire logic                   rst_b,
  input wire logic [GPC_ADDR_W-1:0]  reg_addr,
  input wire logic                   wr_en,
  input wire logic                   rd_en,
  input wire logic [7:0]             wr_data,
  input wire logic [7:0]             rd_data,
  // interrupt side
  input wire logic [GPC_IRQ_N-1:0]   irq1_enable_low,
  input wire logic [2*GPC_IRQ_N-1:0] irq1_priority,
  input wire logic                   shared_source_select_bit,
  // pin side
  input wire logic [8*NPORT-1:0]     port_out_data,
  input wire logic [8*NPORT-1:0]     port_out_en,
  input wire logic [8*NPORT-1:0]     pin_o,
  input wire logic [8*NPORT-1:0]     pin_oe
);
  logic [1:0] up_r;
  logic [7:0] sub_r;
  logic [7:0] oc_r;
  logic [7:0] pri_lo;
  wire        live = (up_r == 2'd3);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // edges since release; outputs may only move once the reset copy is gone
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) up_r <= 2'd0;
    else if (!live) up_r <= up_r + 2'd1;
  end
  // shadow of the port B subregister address
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) sub_r <= 8'h00;
    else if (wr_en && reg_addr == GPC_ADDR_PADDR + GPC_PORT_STRIDE) sub_r <= wr_data;
  end
  // shadow of the port B output control bits
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) oc_r <= 8'h00;
    else if (wr_en && reg_addr == GPC_ADDR_PCTL + GPC_PORT_STRIDE && sub_r == GPC_SUB_OUTCTL) oc_r <= wr_data;
  end
  // enable-low half of each priority code
  always_comb begin
    for (int k = 0; k < 8; k++) pri_lo[k] = irq1_priority[2*k];
  end
  sequence unmapped_rd_s;
    rd_en && reg_addr < GPC_ADDR_ENH1;
  endsequence
  rst_quiet_a: assert property (!live |-> pin_oe == '0 && pin_o == '0)
    else $error("pins active before reset settled");
  rst_pri_a: assert property (!live |-> irq1_priority == '0 && !shared_source_select_bit)
    else $error("priority active before reset settled");
  pri_low_a: assert property (live |-> pri_lo == $past(irq1_enable_low))
    else $error("priority low bits do not follow enable low");
  rd_hold_a: assert property (!rd_en |=> $stable(rd_data))
    else $error("read data moved without a read");
  unmapped_rd_a: assert property (unmapped_rd_s |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  resv_alt_a: assert property (live && port_out_en[5:2] == 4'h0 |=> pin_oe[5:2] == 4'h0)
    else $error("reserved port A pin driven");
  drive_b_a: assert property (live |=> pin_oe[15:8] == $past(port_out_en[15:8] & ~(oc_r & port_out_data[15:8])))
    else $error("port B drive enable wrong");
  level_b_a: assert property (live |=> (pin_oe[15:8] & (pin_o[15:8] ^ $past(port_out_data[15:8]))) == 8'h00)
    else $error("port B driven level wrong");
endmodule
bind gpc_top gpc_checker #(.NPORT(NPORT)) u_chk (.mclk, .rst_b, .reg_addr, .wr_en, .rd_en, .wr_data, .rd_data,
  .irq1_enable_low, .irq1_priority, .shared_source_select_bit, .port_out_data, .port_out_en, .pin_o, .pin_oe);
`default_nettype wire

// ===== gpc_pin_model.sv
// gpc_pin_model: board side of the pins, a pull-up on every line
// assumes pin_o and pin_oe come straight from gpc_top
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_model #(
  parameter int W = 32
) (
  // block drive
  input  wire logic [W-1:0] pin_o,
  input  wire logic [W-1:0] pin_oe,
  // level seen back
  output logic      [W-1:0] pin_i
);
  // a released or open-drain line floats up, never keeps its last value
  always_comb pin_i = (pin_o & pin_oe) | ~pin_oe;
endmodule
`default_nettype wire

// ===== gpio_port_control_tb_top.sv
// gpio_port_control_tb_top: self-checking bench for gpc_top
// assumes gpc_checker binds itself and gpc_pin_model stands for the board
`timescale 1ns/1ps
`default_nettype none
module gpio_port_control_tb_top;
  import gpc_pkg::*;
  logic        mclk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0, timer_one_output = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  wr_data = 8'h00, irq1_enable_low = 8'h00, rd_data, enh, oc[4];
  logic [15:0] irq1_priority, lf = 16'hdbe5;
  logic        shared_source_select_bit;
  logic [31:0] pin_in_sync;
  logic [7:0]  port_c_drive_high;
  logic        t0_in, t1_in, ext_clk;
  logic [31:0] port_out_data = '0, port_out_en = '0, periph_af_data = '0, periph_af_oe = '0, pin_i, pin_o, pin_oe;
  int          errors = 0, n_compared = 0;
  gpc_top dut (.mclk, .rst_b, .reg_addr, .wr_en, .rd_en, .wr_data, .rd_data, .irq1_enable_low, .irq1_priority,
    .shared_source_select_bit, .port_out_data, .port_out_en, .timer_zero_output(1'b0), .timer_zero_comp_out(1'b0),
    .timer_one_output, .timer_one_comp_out(1'b0), .periph_af_data, .periph_af_oe, .pin_i, .pin_o, .pin_oe,
    .pin_in_sync, .port_c_drive_high, .timer_zero_in_or_complement_out(t0_in),
    .timer_one_in_or_complement_out(t1_in), .external_clock_input_function(ext_clk));
  gpc_pin_model board (.pin_o, .pin_oe, .pin_i);
  always #50 mclk = ~mclk;
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask
  // subregister access: address register first, then the control register
  task automatic sw(input int p, input logic [7:0] code, input logic [7:0] d);
    wr(GPC_ADDR_PADDR + 12'(4*p), code);
    wr(GPC_ADDR_PCTL + 12'(4*p), d);
  endtask
  task automatic sr(input int p, input logic [7:0] code, output logic [7:0] d);
    wr(GPC_ADDR_PADDR + 12'(4*p), code);
    rd(GPC_ADDR_PCTL + 12'(4*p), d);
  endtask
  task automatic close_out;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    close_out();
  end
  // main sequence
  initial begin
    logic [7:0] r, lv;
    logic [31:0] d, n, e;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(GPC_ADDR_ENH1, r);
    chk_reg(r, 8'h00);
    for (int p = 0; p < 4; p++) begin
      sr(p, GPC_SUB_OUTCTL, r);
      chk_reg(r, 8'h00);
    end
    wr(12'h000, 8'hff);
    rd(12'h000, r);
    chk_reg(r, 8'h00);
    // random open-drain masks on every port, read back through the subregister
    for (int p = 0; p < 4; p++) begin
      lf = step(lf);
      oc[p] = lf[7:0];
      sw(p, GPC_SUB_OUTCTL, oc[p]);
    end
    for (int p = 0; p < 4; p++) begin
      sr(p, GPC_SUB_OUTCTL, r);
      chk_reg(r, oc[p]);
    end
    // drive strength lives on port C only; the second select exists on B and C only
    sw(2, GPC_SUB_DRIVE, 8'h5a);
    sr(2, GPC_SUB_DRIVE, r);
    chk_reg(r, 8'h5a);
    chk_reg(port_c_drive_high, 8'h5a);
    sw(1, GPC_SUB_SEL2, 8'ha5);
    sr(1, GPC_SUB_SEL2, r);
    chk_reg(r, 8'ha5);
    sw(0, GPC_SUB_SEL2, 8'ha5);
    sr(0, GPC_SUB_SEL2, r);
    chk_reg(r, 8'h00);
    // enable-high 0f with low 33 first gives all four codes
    enh = 8'h0f;
    wr(GPC_ADDR_ENH1, enh);
    rd(GPC_ADDR_ENH1, r);
    chk_reg(r, enh);
    for (int i = 0; i < 6; i++) begin
      lf = step(lf);
      lv = (i == 0) ? 8'h33 : lf[7:0];
      @(posedge mclk);
      irq1_enable_low <= lv;
      @(posedge mclk);
      #1 for (int k = 0; k < 8; k++) e[2*k +: 2] = {enh[k], lv[k]};
      chk_pin({16'h0, irq1_priority}, {16'h0, e[15:0]});
    end
    // shared source enable bit 6 is already off before the switch
    wr(GPC_ADDR_SHSEL, 8'hff);
    rd(GPC_ADDR_SHSEL, r);
    chk_reg(r, 8'h40);
    chk_reg({7'h0, shared_source_select_bit}, 8'h01);
    wr(GPC_ADDR_SHSEL, 8'h00);
    rd(GPC_ADDR_SHSEL, r);
    chk_reg({7'h0, shared_source_select_bit}, 8'h00);
    // bit 6 alone, enabled only once the source select has settled
    enh = 8'h40;
    wr(GPC_ADDR_ENH1, enh);
    @(posedge mclk);
    irq1_enable_low <= 8'h40;
    repeat (2) @(posedge mclk);
    #1 chk_pin({16'h0, irq1_priority}, {16'h0, 16'h3000});
    // random data and enables; open drain cuts only the high level
    repeat (40) begin
      lf = step(lf);
      d = {lf, step(lf)};
      lf = step(step(lf));
      n = {lf, step(lf)};
      @(posedge mclk);
      port_out_data <= d;
      port_out_en <= n;
      periph_af_data <= ~d;
      periph_af_oe <= n ^ d;
      @(posedge mclk);
      #1 e = n & ~({oc[3], oc[2], oc[1], oc[0]} & d) & 32'h01ff_ffff;
      chk_pin(pin_oe & 32'h01ff_ffff, e);
      chk_pin(pin_o & e, d & e);
    end
    // port A pin 7 on its timer alone, open drain on and off
    @(posedge mclk);
    port_out_en <= '0;
    periph_af_oe <= 32'h0000_0080;
    sw(0, GPC_SUB_AFEN, 8'h80);
    for (int i = 0; i < 4; i++) begin
      sw(0, GPC_SUB_OUTCTL, {i[1], 7'h0});
      @(posedge mclk);
      timer_one_output <= i[0];
      repeat (2) @(posedge mclk);
      #1 e = {30'h0, ~(i[1] & i[0]), ~i[1] & i[0]};
      chk_pin({30'h0, pin_oe[7], pin_o[7] & pin_oe[7]}, e);
    end
    // all pins released: the board pulls them up, timer and clock inputs follow them
    @(posedge mclk);
    port_out_en <= '0;
    periph_af_oe <= '0;
    sw(0, GPC_SUB_AFEN, 8'h41);
    sw(1, GPC_SUB_AFEN, 8'h08);
    repeat (8) @(posedge mclk);
    #1 chk_pin(pin_in_sync, 32'hffff_ffff);
    chk_pin({29'h0, t0_in, t1_in, ext_clk}, 32'h0000_0007);
    // pin A0 now driven low by the timer complement output
    @(posedge mclk);
    periph_af_oe <= 32'h0000_0001;
    repeat (8) @(posedge mclk);
    #1 chk_pin(pin_in_sync, 32'hffff_fffe);
    chk_pin({29'h0, t0_in, t1_in, ext_clk}, 32'h0000_0003);
    // alternate functions off again: the inputs are gated to zero
    sw(0, GPC_SUB_AFEN, 8'h00);
    sw(1, GPC_SUB_AFEN, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk_pin({29'h0, t0_in, t1_in, ext_clk}, 32'h0000_0000);
    close_out();
  end
endmodule
`default_nettype wire
